/* design/pmt_pkg.sv */
package pmt_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_COUNT   = 8'h00;
    localparam logic [7:0] OFS_PERIOD  = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_FLAG    = 8'h0c;
    localparam logic [7:0] OFS_ENABLE  = 8'h10;
    localparam logic [7:0] OFS_SHIFT   = 8'h14;

    localparam int CNT_W  = 8;
    localparam int PRE_W  = 6;
    localparam int POST_W = 4;

    localparam logic [CNT_W-1:0] COUNT_RST  = 8'h00;
    localparam logic [CNT_W-1:0] PERIOD_RST = 8'hff;
    localparam logic [CNT_W-1:0] COUNT_ONE  = 8'h01;

    // timer_control field positions
    localparam int CTL_PRE_LSB  = 0;
    localparam int CTL_RUN_BIT  = 2;
    localparam int CTL_POST_LSB = 3;
    // match flag / enable position in the flag and enable registers, and shift select bit position in the shift register
    localparam int FLAG_BIT     = 1;
    localparam int SHIFT_BIT    = 0;

    // Instruction clock is the reference clock divided by four
    localparam logic [1:0] INSTR_LAST = 2'h3;

    // Prescaler terminal counts for ratios 1, 4, 16, 64
    localparam logic [PRE_W-1:0] PRE_LIM_1  = 6'h00;
    localparam logic [PRE_W-1:0] PRE_LIM_4  = 6'h03;
    localparam logic [PRE_W-1:0] PRE_LIM_16 = 6'h0f;
    localparam logic [PRE_W-1:0] PRE_LIM_64 = 6'h3f;

    typedef enum {REG_COUNT, REG_PERIOD, REG_CONTROL, REG_FLAG, REG_ENABLE,
                  REG_SHIFT, REG_NONE} pmt_reg_t;
endpackage

/* design/pmt_postscaler.sv */
`timescale 1ns/1ns
module pmt_postscaler (
    input  wire logic     clk,
    input  wire logic     rst,
    pmt_scaler_if.post    sc
);
    logic [pmt_pkg::POST_W-1:0] cnt;

    // Select n completes after n+1 matches
    assign sc.post_done = sc.match && (cnt == sc.post_sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (sc.clear) begin
            cnt <= '0;
        end else if (sc.post_done) begin
            cnt <= '0;
        end else if (sc.match) begin
            cnt <= cnt + 4'h1;
        end
    end

    property p_post_one;
        @(posedge clk) disable iff (rst)
            (sc.post_sel == 4'h0 && sc.match && !sc.clear) |-> sc.post_done;
    endproperty
    a_post_one: assert property (p_post_one) else $error("ratio 1 missed match");

    property p_post_clear;
        @(posedge clk) disable iff (rst) sc.clear |=> (cnt == '0);
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");
endmodule // pmt_postscaler

/* design/pmt_prescaler.sv */
`timescale 1ns/1ns
module pmt_prescaler (
    input  wire logic     clk,
    input  wire logic     rst,
    pmt_scaler_if.pre     sc
);
    logic [pmt_pkg::PRE_W-1:0] cnt;

    function automatic logic [pmt_pkg::PRE_W-1:0] pre_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0: pre_limit = pmt_pkg::PRE_LIM_1;
            2'h1: pre_limit = pmt_pkg::PRE_LIM_4;
            2'h2: pre_limit = pmt_pkg::PRE_LIM_16;
            2'h3: pre_limit = pmt_pkg::PRE_LIM_64;
        endcase
    endfunction

    assign sc.pre_tick = sc.instr_tick && (cnt == pre_limit(sc.pre_sel));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (sc.clear) begin
            cnt <= '0;
        end else if (sc.pre_tick) begin
            cnt <= '0;
        end else if (sc.instr_tick) begin
            cnt <= cnt + 6'h01;
        end
    end

    property p_pre_clear;
        @(posedge clk) disable iff (rst) sc.clear |=> (cnt == '0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");
endmodule // pmt_prescaler

/* design/pmt_scaler_if.sv */
`timescale 1ns/1ns
interface pmt_scaler_if;
    logic       clear;
    logic       instr_tick;
    logic [1:0] pre_sel;
    logic       pre_tick;
    logic       match;
    logic [3:0] post_sel;
    logic       post_done;

    modport core (output clear, instr_tick, pre_sel, match, post_sel,
                  input pre_tick, post_done);
    modport pre  (input clear, instr_tick, pre_sel, output pre_tick);
    modport post (input clear, match, post_sel, output post_done);
endinterface

/* design/pmt_timer.sv */
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
module pmt_timer (
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        SLEEP_I,
    output logic             MATCH_O,
    output logic             PWM_TIMEBASE_O,
    output logic             SHIFT_CLK_O,
    output logic             IRQ_O
);
    pmt_scaler_if sc ();

    logic [pmt_pkg::CNT_W-1:0]  timer_count;
    logic [pmt_pkg::CNT_W-1:0]  period_value;
    logic [1:0]                 clock_prescale_select;
    logic                       timer_run_enable;
    logic [3:0]                 output_postscale_select;
    logic                       match_interrupt_flag;
    logic                       match_interrupt_enable;
    logic                       shift_clock_select;
    logic [1:0]                 instr_phase;
    logic                       match;
    logic                       irq;
    logic                       setup;
    logic                       access;
    logic                       wr;
    pmt_pkg::pmt_reg_t          sel;
    logic                       count_adv;
    logic                       at_period;
    logic [31:0]                next_rdata;

    function automatic pmt_pkg::pmt_reg_t reg_decode(input logic [7:0] addr);
        unique case (addr)
            pmt_pkg::OFS_COUNT:   reg_decode = pmt_pkg::REG_COUNT;
            pmt_pkg::OFS_PERIOD:  reg_decode = pmt_pkg::REG_PERIOD;
            pmt_pkg::OFS_CONTROL: reg_decode = pmt_pkg::REG_CONTROL;
            pmt_pkg::OFS_FLAG:    reg_decode = pmt_pkg::REG_FLAG;
            pmt_pkg::OFS_ENABLE:  reg_decode = pmt_pkg::REG_ENABLE;
            pmt_pkg::OFS_SHIFT:   reg_decode = pmt_pkg::REG_SHIFT;
            default:              reg_decode = pmt_pkg::REG_NONE;
        endcase
    endfunction

    // APB decode; zero wait states
    assign setup     = PSEL_I && !PENABLE_I;
    assign access    = PSEL_I && PENABLE_I;
    assign wr        = access && PWRITE_I;
    assign sel       = reg_decode(PADDR_I);
    assign PREADY_O  = access;
    assign PSLVERR_O = access && (sel == pmt_pkg::REG_NONE);

    // Instruction clock phase, free running
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            instr_phase <= '0;
        end else begin
            instr_phase <= instr_phase + 2'h1;
        end
    end

    // Sleep and run bit gate ticks before the prescaler, so it freezes too
    assign sc.instr_tick = (instr_phase == pmt_pkg::INSTR_LAST)
                           && timer_run_enable && !SLEEP_I;
    assign sc.pre_sel    = clock_prescale_select;
    assign sc.post_sel   = output_postscale_select;
    assign sc.match      = match;
    assign sc.clear      = wr && (sel == pmt_pkg::REG_COUNT
                                  || sel == pmt_pkg::REG_CONTROL);

    pmt_prescaler u_pre (
        .clk (REF_CLK_I),
        .rst (SYS_RST_I),
        .sc  (sc)
    );

    pmt_postscaler u_post (
        .clk (REF_CLK_I),
        .rst (SYS_RST_I),
        .sc  (sc)
    );

    assign count_adv = sc.pre_tick;
    assign at_period = (timer_count == period_value);

    // Counter; a software write wins over a tick in the same cycle
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            timer_count <= pmt_pkg::COUNT_RST;
        end else if (wr && sel == pmt_pkg::REG_COUNT) begin
            timer_count <= PWDATA_I[pmt_pkg::CNT_W-1:0];
        end else if (count_adv) begin
            if (at_period) begin
                timer_count <= pmt_pkg::COUNT_RST;
            end else begin
                timer_count <= timer_count + pmt_pkg::COUNT_ONE;
            end
        end
    end

    // Unscaled match pulse, one cycle per period
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            match <= 1'b0;
        end else begin
            match <= count_adv && at_period
                     && !(wr && sel == pmt_pkg::REG_COUNT);
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            period_value <= pmt_pkg::PERIOD_RST;
        end else if (wr && sel == pmt_pkg::REG_PERIOD) begin
            period_value <= PWDATA_I[pmt_pkg::CNT_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            clock_prescale_select   <= '0;
            timer_run_enable        <= 1'b0;
            output_postscale_select <= '0;
        end else if (wr && sel == pmt_pkg::REG_CONTROL) begin
            clock_prescale_select   <= PWDATA_I[pmt_pkg::CTL_PRE_LSB +: 2];
            timer_run_enable        <= PWDATA_I[pmt_pkg::CTL_RUN_BIT];
            output_postscale_select <= PWDATA_I[pmt_pkg::CTL_POST_LSB +: 4];
        end
    end

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            match_interrupt_flag <= 1'b0;
        end else if (sc.post_done) begin
            match_interrupt_flag <= 1'b1;
        end else if (wr && sel == pmt_pkg::REG_FLAG
                     && !PWDATA_I[pmt_pkg::FLAG_BIT]) begin
            match_interrupt_flag <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            match_interrupt_enable <= 1'b0;
        end else if (wr && sel == pmt_pkg::REG_ENABLE) begin
            match_interrupt_enable <= PWDATA_I[pmt_pkg::FLAG_BIT];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            shift_clock_select <= 1'b0;
        end else if (wr && sel == pmt_pkg::REG_SHIFT) begin
            shift_clock_select <= PWDATA_I[pmt_pkg::SHIFT_BIT];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq <= 1'b0;
        end else begin
            irq <= match_interrupt_flag && match_interrupt_enable;
        end
    end

    assign IRQ_O          = irq;
    assign MATCH_O        = match;
    assign PWM_TIMEBASE_O = match;
    assign SHIFT_CLK_O    = match && shift_clock_select;

    // Read data captured in the setup phase, stable through access
    always_comb begin
        next_rdata = '0;
        unique case (sel)
            pmt_pkg::REG_COUNT:   next_rdata[pmt_pkg::CNT_W-1:0] = timer_count;
            pmt_pkg::REG_PERIOD:  next_rdata[pmt_pkg::CNT_W-1:0] = period_value;
            pmt_pkg::REG_CONTROL: begin
                next_rdata[pmt_pkg::CTL_PRE_LSB +: 2]  = clock_prescale_select;
                next_rdata[pmt_pkg::CTL_RUN_BIT]       = timer_run_enable;
                next_rdata[pmt_pkg::CTL_POST_LSB +: 4] = output_postscale_select;
            end
            pmt_pkg::REG_FLAG:    next_rdata[pmt_pkg::FLAG_BIT] = match_interrupt_flag;
            pmt_pkg::REG_ENABLE:  next_rdata[pmt_pkg::FLAG_BIT] = match_interrupt_enable;
            pmt_pkg::REG_SHIFT:   next_rdata[pmt_pkg::SHIFT_BIT] = shift_clock_select;
            pmt_pkg::REG_NONE:    next_rdata = '0;
        endcase
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= '0;
        end else if (setup) begin
            PRDATA_O <= next_rdata;
        end
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic cnt_wr;
    assign cnt_wr = wr && sel == pmt_pkg::REG_COUNT;

    property p_instr_div;
        sc.instr_tick |=> !sc.instr_tick [*3];
    endproperty
    a_instr_div: assert property (p_instr_div) else $error("tick faster than div 4");

    property p_count_inc;
        (count_adv && !at_period && !cnt_wr) |=> timer_count == $past(timer_count) + 8'h01;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count did not step");

    property p_match_reload;
        match |-> timer_count == pmt_pkg::COUNT_RST;
    endproperty
    a_match_reload: assert property (p_match_reload) else $error("no reload at match");

    property p_match_cause;
        (count_adv && at_period && !cnt_wr) |=> match ##1 !match;
    endproperty
    a_match_cause: assert property (p_match_cause) else $error("match pulse wrong");

    property p_sleep_hold;
        (SLEEP_I && !wr) |=> $stable(timer_count) && $stable(period_value);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("changed in sleep");

    property p_run_hold;
        (!timer_run_enable && !cnt_wr) |=> $stable(timer_count);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("counted while off");

    property p_flag_sticky;
        match_interrupt_flag && !(wr && sel == pmt_pkg::REG_FLAG) |=> match_interrupt_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_irq_path;
        (sc.post_done && match_interrupt_enable && !(wr && sel == pmt_pkg::REG_ENABLE))
            |-> ##2 IRQ_O;
    endproperty
    a_irq_path: assert property (p_irq_path) else $error("interrupt not raised");

    property p_irq_gate;
        !$past(match_interrupt_enable) |-> !IRQ_O;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

    // Sampled-value helpers, so that past values are taken of plain signals
    logic [pmt_pkg::CNT_W-1:0] wdata_lo;
    logic                      hit;
    assign wdata_lo = PWDATA_I[pmt_pkg::CNT_W-1:0];
    assign hit      = count_adv && at_period;

    property p_count_wr;
        cnt_wr |=> timer_count == $past(wdata_lo);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost");

    property p_period_wr;
        (wr && sel == pmt_pkg::REG_PERIOD) |=> period_value == $past(wdata_lo);
    endproperty
    a_period_wr: assert property (p_period_wr) else $error("period write lost");

    property p_period_hold;
        !(wr && sel == pmt_pkg::REG_PERIOD) |=> $stable(period_value);
    endproperty
    a_period_hold: assert property (p_period_hold) else $error("period changed alone");

    property p_match_src;
        match |-> $past(hit);
    endproperty
    a_match_src: assert property (p_match_src) else $error("match without period hit");

    property p_match_single;
        match |=> !match;
    endproperty
    a_match_single: assert property (p_match_single) else $error("match pulse too long");

    property p_cnt_wr_no_match;
        cnt_wr |=> !match;
    endproperty
    a_cnt_wr_no_match: assert property (p_cnt_wr_no_match) else $error("match after write");

    property p_count_idle;
        (!count_adv && !cnt_wr) |=> $stable(timer_count);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("count moved without tick");

    property p_flag_set;
        sc.post_done |=> match_interrupt_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_irq_follow;
        IRQ_O |-> $past(match_interrupt_flag) && $past(match_interrupt_enable);
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("interrupt without cause");

    property p_sleep_quiet;
        SLEEP_I |-> !sc.instr_tick;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("tick during sleep");

    property p_rdata_hold;
        !setup |=> $stable(PRDATA_O);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    c_match:    cover property (match);
    c_flag:     cover property (sc.post_done && output_postscale_select != 4'h0);
    c_sleep:    cover property (SLEEP_I && timer_run_enable);
    c_rd_count: cover property (access && !PWRITE_I && sel == pmt_pkg::REG_COUNT);
    c_pre64:    cover property (count_adv && clock_prescale_select == 2'h3);
endmodule // pmt_timer

/* verification/pmt_timer_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, (exp), (got)); end end

module pmt_timer_tb;
    logic        ref_clk  = 1'h0;
    logic        sys_rst  = 1'h1;
    logic        psel     = 1'h0;
    logic        penable  = 1'h0;
    logic        pwrite   = 1'h0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic        sleep    = 1'h0;
    logic        shift_sel = 1'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        match;
    logic        pwm_tb;
    logic        shift_clk;
    logic        irq;
    logic [31:0] d;
    logic [31:0] d2;
    logic        e;
    int          err_total   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          t;
    int          cnt;
    int          k;
    int          ratio[4]    = '{1, 4, 16, 64};
    logic [3:0]  posts[3]    = '{4'h0, 4'h3, 4'hf};

    pmt_timer i_dut (
        .REF_CLK_I      (ref_clk),
        .SYS_RST_I      (sys_rst),
        .PSEL_I         (psel),
        .PENABLE_I      (penable),
        .PWRITE_I       (pwrite),
        .PADDR_I        (paddr),
        .PWDATA_I       (pwdata),
        .PRDATA_O       (prdata),
        .PREADY_O       (pready),
        .PSLVERR_O      (pslverr),
        .SLEEP_I        (sleep),
        .MATCH_O        (match),
        .PWM_TIMEBASE_O (pwm_tb),
        .SHIFT_CLK_O    (shift_clk),
        .IRQ_O          (irq)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the longest expected sequence
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            final_report();
        end
    end

    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                            output logic [31:0] rdat, output logic err);
        @(posedge ref_clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        // No local limit: this wait ends on pready, or by the bench timeout if pready never rises
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic apb_wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] r;
        logic        x;
        apb_xfer(1'h1, addr, wd, r, x);
    endtask

    task automatic apb_rd(input logic [7:0] addr, output logic [31:0] r);
        logic x;
        apb_xfer(1'h0, addr, 32'h0, r, x);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] pre, input logic run,
                                        input logic [3:0] post);
        ctl = 32'h0;
        ctl[pmt_pkg::CTL_PRE_LSB +: 2]  = pre;
        ctl[pmt_pkg::CTL_RUN_BIT]       = run;
        ctl[pmt_pkg::CTL_POST_LSB +: 4] = post;
    endfunction

    // Cycles up to and including the next match pulse
    task automatic wait_match(output int w);
        w = 0;
        do begin
            @(posedge ref_clk);
            #1;
            w++;
            `CHK("pwm_timebase", match, pwm_tb)
            `CHK("shift_clk", match & shift_sel, shift_clk)
        end while (match !== 1'h1 && w < 3000);
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        apb_rd(pmt_pkg::OFS_COUNT, d);
        `CHK("count_reset", 32'h00000000, d)
        apb_rd(pmt_pkg::OFS_PERIOD, d);
        `CHK("period_reset", 32'h000000ff, d)
        apb_xfer(1'h0, 8'h3c, 32'h0, d, e);
        `CHK("unmapped_err", 1'h1, e)
        `CHK("unmapped_data", 32'h00000000, d)
        apb_wr(pmt_pkg::OFS_PERIOD, 32'hffffff5a);
        apb_rd(pmt_pkg::OFS_PERIOD, d);
        `CHK("period_rw", 32'h0000005a, d)
        apb_wr(pmt_pkg::OFS_COUNT, 32'h00000033);
        repeat (20) @(posedge ref_clk);
        apb_rd(pmt_pkg::OFS_COUNT, d);
        `CHK("count_hold_off", 32'h00000033, d)
        apb_wr(pmt_pkg::OFS_PERIOD, 32'h00000002);
        for (int c = 0; c < 4; c++) begin
            shift_sel = c[0];
            apb_wr(pmt_pkg::OFS_SHIFT, {31'h0, shift_sel});
            apb_wr(pmt_pkg::OFS_CONTROL, ctl(c[1:0], 1'h1, 4'h0));
            wait_match(t);
            wait_match(t);
            `CHK("match_interval", 3 * 4 * ratio[c], t)
        end
        apb_wr(pmt_pkg::OFS_PERIOD, 32'h00000000);
        apb_wr(pmt_pkg::OFS_ENABLE, 32'h00000002);
        for (int p = 0; p < 3; p++) begin
            apb_wr(pmt_pkg::OFS_CONTROL, ctl(2'h0, 1'h0, posts[p]));
            apb_wr(pmt_pkg::OFS_FLAG, 32'h00000000);
            apb_wr(pmt_pkg::OFS_COUNT, 32'h00000000);
            apb_rd(pmt_pkg::OFS_FLAG, d);
            `CHK("flag_cleared", 32'h00000000, d)
            apb_wr(pmt_pkg::OFS_CONTROL, ctl(2'h0, 1'h1, posts[p]));
            cnt = 0;
            k = 0;
            while (irq !== 1'h1 && k < 1000) begin
                @(posedge ref_clk);
                #1;
                k++;
                if (match === 1'h1) cnt++;
            end
            `CHK("post_ratio", int'(posts[p]) + 1, cnt)
        end
        repeat (40) @(posedge ref_clk);
        apb_wr(pmt_pkg::OFS_FLAG, 32'h00000002);
        apb_rd(pmt_pkg::OFS_FLAG, d);
        `CHK("flag_latched", 32'h00000002, d)
        apb_wr(pmt_pkg::OFS_ENABLE, 32'h00000000);
        repeat (3) @(posedge ref_clk);
        `CHK("irq_masked", 1'h0, irq)
        apb_wr(pmt_pkg::OFS_CONTROL, ctl(2'h0, 1'h0, 4'h0));
        apb_wr(pmt_pkg::OFS_FLAG, 32'h00000000);
        apb_rd(pmt_pkg::OFS_FLAG, d);
        `CHK("flag_sw_clear", 32'h00000000, d)
        // Write lands mid prescale; a stale prescaler would match about 30 cycles early
        apb_wr(pmt_pkg::OFS_CONTROL, ctl(2'h2, 1'h1, 4'h0));
        wait_match(t);
        repeat (30) @(posedge ref_clk);
        apb_wr(pmt_pkg::OFS_COUNT, 32'h00000000);
        wait_match(t);
        `CHK("prescale_cleared", 1'h1, (t >= 56 && t <= 66))
        apb_wr(pmt_pkg::OFS_PERIOD, 32'h000000ff);
        apb_wr(pmt_pkg::OFS_CONTROL, ctl(2'h0, 1'h1, 4'h0));
        repeat (20) @(posedge ref_clk);
        sleep <= 1'h1;
        repeat (2) @(posedge ref_clk);
        apb_rd(pmt_pkg::OFS_COUNT, d);
        repeat (40) @(posedge ref_clk);
        apb_rd(pmt_pkg::OFS_COUNT, d2);
        `CHK("count_sleep", d, d2)
        apb_rd(pmt_pkg::OFS_PERIOD, d2);
        `CHK("period_sleep", 32'h000000ff, d2)
        sleep <= 1'h0;
        repeat (20) @(posedge ref_clk);
        apb_rd(pmt_pkg::OFS_COUNT, d2);
        `CHK("count_resumes", 1'h1, (d2 != d))
        final_report();
    end
endmodule // pmt_timer_tb
